/* inc/dts_defines.svh */
// Constants for the dual trace digital storage block
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH
// Instrument bus addresses
`define DTS_ADDR_STORE_WR   8'h7a
`define DTS_ADDR_CTRL_WR    8'h7b
`define DTS_ADDR_STORE_RD   8'hfa
`define DTS_ADDR_STATUS_RD  8'hfb
// Subaddresses behind the store write port
`define DTS_SUB_MODE        3'h0
`define DTS_SUB_THRESH      3'h1
`define DTS_SUB_MARK1_LO    3'h2
`define DTS_SUB_MARK2_LO    3'h3
`define DTS_SUB_MARK_HI     3'h4
`define DTS_SUB_RDPTR_LO    3'h5
`define DTS_SUB_RDPTR_HI    3'h6
// Control write field positions
`define DTS_CTRL_SECT_BIT   3
// Mode field positions
`define DTS_MODE_MAXHOLD    0
`define DTS_MODE_FREEZE     1
`define DTS_MODE_DIFF       2
`define DTS_MODE_VIEW_A     3
`define DTS_MODE_VIEW_B     4
// Table geometry
`define DTS_POINTS          500
`define DTS_DISP_POINTS     1000
// Reset values
`define DTS_MODE_RST        8'h18
`define DTS_THRESH_RST      8'h80
// Timing: processor clock derived from the system clock
`define DTS_SYS_CLK_HZ      200000000
`define DTS_PROC_CLK_HZ     1000000
`define DTS_PROC_DIV        (`DTS_SYS_CLK_HZ / `DTS_PROC_CLK_HZ)
`endif

/* inc/dts_pkg.sv */
// Types shared by the dual trace digital storage block
package dts_pkg;
  // One committed table entry
  typedef struct packed {
    logic       bank;   // 0 = table A, 1 = table B
    logic [8:0] idx;    // Table position
    logic [7:0] data;   // Amplitude
  } dts_wr_t;

  // Acquisition states
  typedef enum logic [1:0] {
    DTS_ACQ_IDLE  = 2'b00,
    DTS_ACQ_RUN   = 2'b01,
    DTS_ACQ_STALL = 2'b10
  } dts_acq_t;
endpackage

/* design/dts_buffer.sv */
// Two-entry buffer for committed table entries
`timescale 1ns/1ps
`include "dts_defines.svh"
module dts_buffer
  import dts_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_in,
  input  wire logic    rst_n_in,
  // Fill side
  input  wire dts_wr_t in_data_in,
  input  wire logic    in_valid_in,
  output logic         in_ready_out,
  // Drain side
  output dts_wr_t      out_data_out,
  output logic         out_valid_out,
  input  wire logic    out_ready_in
);
  dts_wr_t    slot_reg [2];  // Storage slots
  logic       rd_reg;        // Read slot
  logic       wr_reg;        // Write slot
  logic [1:0] cnt_reg;       // Fill level

  logic push;
  logic pop;
  assign push          = in_valid_in && (cnt_reg != 2'h2);
  assign pop           = out_valid_out && out_ready_in;
  assign in_ready_out  = (cnt_reg != 2'h2);
  assign out_valid_out = (cnt_reg != 2'h0);
  assign out_data_out  = slot_reg[rd_reg];

  // Pointers and level
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_reg  <= 1'b0;
      wr_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
        wr_reg <= ~wr_reg;
      if (pop)
        rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Slot storage, no reset needed
  always_ff @(posedge clk_in)
  begin
    if (push)
      slot_reg[wr_reg] <= in_data_in;
  end
endmodule

/* design/dts_top.sv */
// Dual trace digital storage: acquisition, tables, display and bus port
`timescale 1ns/1ps
`include "dts_defines.svh"
// Notes on behaviour
// - Two banks of 500 stored amplitudes
// - Digitised vertical level stored per entry
// - Sweep code selects table position
// - Tables redrawn to X and Y outputs
// - Max hold keeps largest per point
// - Freeze stops writes to table A
// - Difference shows B minus A
// - Above threshold peak, below averaged
// - View selects A, B or both
// - Only 7A, 7B, FA, FB decoded
// - Section select decides responding registers
// - 7A split by 3-bit subaddress in horizontal section
// - Update marker at acquired position
// - Two controller-placed waveform markers
// - B always updated, A unless frozen or in difference mode
// - B positions interlaced with A
// - Storage timed by 1 MHz tick
module dts_top
  import dts_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  // Digitised signal pins
  input  wire logic [7:0] y_code_in,
  input  wire logic [9:0] x_code_in,
  input  wire logic       sample_strobe_in,
  // Instrument bus pins
  input  wire logic [7:0] bus_addr_in,
  input  wire logic [7:0] bus_data_in,
  input  wire logic       bus_wr_in,
  input  wire logic       bus_rd_in,
  output logic [7:0]      bus_data_out,
  output logic            bus_data_oe_out,
  // Display converter outputs
  output logic [9:0]      disp_x_out,
  output logic [7:0]      disp_y_out,
  output logic            disp_trace_out,
  output logic            upd_marker_out,
  output logic            wave_marker_out
);
  logic [1:0] rst_sync_reg;  // Reset release stages
  logic       rst_n;
  // Pin synchronisers, stage one read only by stage two
  logic [20:0] pin_s1_reg;
  logic [20:0] pin_s2_reg;
  logic [15:0] bus_s1_reg;   // Address and write data, stage one
  logic [15:0] bus_s2_reg;   // Address and write data, stage two
  logic        strb_d_reg;   // Delayed copies for edge detect
  logic        wr_d_reg;
  logic        rd_d_reg;
  // Registers
  logic [2:0]  sub_reg;      // Subaddress
  logic        sect_reg;     // 0 horizontal, 1 vertical
  logic [7:0]  mode_reg;
  logic [7:0]  thresh_reg;
  logic [9:0]  mark1_reg;
  logic [9:0]  mark2_reg;
  logic [8:0]  rdptr_reg;
  logic        rdbank_reg;
  // Processor tick
  logic [7:0]  div_reg;
  logic        tick_reg;
  // Acquisition
  dts_acq_t    acq_reg;
  logic [9:0]  acq_x_reg;
  logic [7:0]  peak_reg;
  logic [7:0]  avg_reg;
  dts_wr_t     commit_reg;
  logic        commit_v_reg;
  // Tables
  logic [7:0]  tab_a [`DTS_POINTS];
  logic [7:0]  tab_b [`DTS_POINTS];
  // Display
  logic [9:0]  dptr_reg;
  logic        trace_reg;

  // Buffer wiring
  dts_wr_t     drain_data;
  logic        drain_valid;
  logic        fill_ready;
  logic        drain_take;

  // Saturating difference
  function automatic logic [7:0] sat_sub(input logic [7:0] b, input logic [7:0] a);
    sat_sub = (b > a) ? (b - a) : 8'h00;
  endfunction

  // Larger of two amplitudes
  function automatic logic [7:0] max8(input logic [7:0] p, input logic [7:0] q);
    max8 = (p > q) ? p : q;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Pin synchronisers; data must settle before its strobe
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 21'h0;
      pin_s2_reg <= 21'h0;
      bus_s1_reg <= 16'h0000;
      bus_s2_reg <= 16'h0000;
      strb_d_reg <= 1'b0;
      wr_d_reg   <= 1'b0;
      rd_d_reg   <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {sample_strobe_in, bus_wr_in, bus_rd_in, x_code_in, y_code_in};
      pin_s2_reg <= pin_s1_reg;
      bus_s1_reg <= {bus_addr_in, bus_data_in};
      bus_s2_reg <= bus_s1_reg;
      strb_d_reg <= pin_s2_reg[20];
      wr_d_reg   <= pin_s2_reg[19];
      rd_d_reg   <= pin_s2_reg[18];
    end
  end

  logic [7:0] y_s;
  logic [9:0] x_s;
  logic       smp_ev;
  logic       wr_ev;
  logic       rd_ev;
  assign y_s    = pin_s2_reg[7:0];
  assign x_s    = pin_s2_reg[17:8];
  assign smp_ev = pin_s2_reg[20] && !strb_d_reg;
  assign wr_ev  = pin_s2_reg[19] && !wr_d_reg;
  assign rd_ev  = pin_s2_reg[18] && !rd_d_reg;

  // Address and write data, synced in step with their strobes
  logic [7:0] addr_s;
  logic [7:0] wdat_s;
  assign addr_s = bus_s2_reg[15:8];
  assign wdat_s = bus_s2_reg[7:0];

  // Address decode: exactly four addresses respond
  logic wr_store;
  logic wr_ctrl;
  logic rd_store;
  logic rd_stat;
  assign wr_store = wr_ev && (addr_s == `DTS_ADDR_STORE_WR);
  assign wr_ctrl  = wr_ev && (addr_s == `DTS_ADDR_CTRL_WR);
  assign rd_store = rd_ev && (addr_s == `DTS_ADDR_STORE_RD);
  assign rd_stat  = rd_ev && (addr_s == `DTS_ADDR_STATUS_RD);

  // Processor tick: one pulse per 1 MHz period
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (div_reg == 8'(`DTS_PROC_DIV - 1));
      div_reg  <= (div_reg == 8'(`DTS_PROC_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // Control word: subaddress and section select
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_reg  <= 3'h0;
      sect_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sub_reg  <= wdat_s[2:0];
      sect_reg <= wdat_s[`DTS_CTRL_SECT_BIT];
    end
  end

  // Store port writes, steered by section and subaddress
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg   <= `DTS_MODE_RST;
      thresh_reg <= `DTS_THRESH_RST;
      mark1_reg  <= 10'h000;
      mark2_reg  <= 10'h000;
    end
    else if (wr_store && sect_reg)
      thresh_reg <= wdat_s;  // Vertical section owns the threshold
    else if (wr_store)
    begin
      case (sub_reg)
        `DTS_SUB_MODE:     mode_reg        <= wdat_s;
        `DTS_SUB_THRESH:   thresh_reg      <= wdat_s;
        `DTS_SUB_MARK1_LO: mark1_reg[7:0]  <= wdat_s;
        `DTS_SUB_MARK2_LO: mark2_reg[7:0]  <= wdat_s;
        `DTS_SUB_MARK_HI:
        begin
          mark1_reg[9:8] <= wdat_s[1:0];
          mark2_reg[9:8] <= wdat_s[3:2];
        end
        default: ;
      endcase
    end
  end

  // Read pointer: set over the bus, advanced by each store read
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdptr_reg  <= 9'h000;
      rdbank_reg <= 1'b0;
    end
    else if (wr_store && !sect_reg && sub_reg == `DTS_SUB_RDPTR_LO)
      rdptr_reg[7:0] <= wdat_s;
    else if (wr_store && !sect_reg && sub_reg == `DTS_SUB_RDPTR_HI)
    begin
      rdptr_reg[8] <= wdat_s[0];
      rdbank_reg   <= wdat_s[1];
    end
    else if (rd_store)
      rdptr_reg <= (rdptr_reg == 9'(`DTS_POINTS - 1)) ? 9'h000 : rdptr_reg + 9'h001;
  end

  // Read data and drive enable; driven while the read strobe stands
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_data_out    <= 8'h00;
      bus_data_oe_out <= 1'b0;
    end
    else
    begin
      bus_data_oe_out <= pin_s2_reg[18] && (addr_s == `DTS_ADDR_STORE_RD ||
                                            addr_s == `DTS_ADDR_STATUS_RD);
      if (rd_store)
        bus_data_out <= rdbank_reg ? tab_b[rdptr_reg] : tab_a[rdptr_reg];
      else if (rd_stat && sect_reg)
        bus_data_out <= y_s;  // Vertical section shows live sample
      else if (rd_stat)
        bus_data_out <= {2'b00, commit_v_reg, !fill_ready, mode_reg[`DTS_MODE_FREEZE],
                         sect_reg, acq_x_reg[9:8]};
    end
  end

  // Acquisition: peak and smoothed mean per position, commit on position change
  logic       new_pos;
  logic       stalled;
  logic [7:0] chosen;
  assign new_pos = (x_s != acq_x_reg);
  assign stalled = commit_v_reg && !fill_ready;
  assign chosen  = (peak_reg >= thresh_reg) ? peak_reg : avg_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acq_reg      <= DTS_ACQ_IDLE;
      acq_x_reg    <= 10'h000;
      peak_reg     <= 8'h00;
      avg_reg      <= 8'h00;
      commit_reg   <= '0;
      commit_v_reg <= 1'b0;
    end
    else
    begin
      if (commit_v_reg && fill_ready)
        commit_v_reg <= 1'b0;
      case (acq_reg)
        DTS_ACQ_IDLE:
          if (smp_ev && x_s < 10'(`DTS_DISP_POINTS))
          begin
            acq_x_reg <= x_s;
            peak_reg  <= y_s;
            avg_reg   <= y_s;
            acq_reg   <= DTS_ACQ_RUN;
          end
        DTS_ACQ_RUN:
          if (stalled)
            acq_reg <= DTS_ACQ_STALL;  // Samples dropped while full
          else if (smp_ev && x_s < 10'(`DTS_DISP_POINTS))
          begin
            if (new_pos)
            begin
              // Even codes fill A, odd codes fill B, interlacing them
              commit_reg   <= '{bank: acq_x_reg[0], idx: acq_x_reg[9:1], data: chosen};
              commit_v_reg <= 1'b1;
              acq_x_reg    <= x_s;
              peak_reg     <= y_s;
              avg_reg      <= y_s;
            end
            else
            begin
              peak_reg <= max8(peak_reg, y_s);
              avg_reg  <= 8'(({1'b0, avg_reg} + {1'b0, y_s}) >> 1);
            end
          end
        DTS_ACQ_STALL:
          if (!stalled)
            acq_reg <= DTS_ACQ_RUN;
        default:
          acq_reg <= DTS_ACQ_IDLE;
      endcase
    end
  end

  // Commit buffer between acquisition and tables
  dts_buffer u_buf
  (
    .clk_in        (clk_sys_in),
    .rst_n_in      (rst_n),
    .in_data_in    (commit_reg),
    .in_valid_in   (commit_v_reg),
    .in_ready_out  (fill_ready),
    .out_data_out  (drain_data),
    .out_valid_out (drain_valid),
    .out_ready_in  (tick_reg)
  );
  assign drain_take = drain_valid && tick_reg;

  // Table writes; A is held in freeze and difference modes
  logic       a_hold;
  logic [7:0] old_val;
  logic [7:0] new_val;
  assign a_hold  = mode_reg[`DTS_MODE_FREEZE] || mode_reg[`DTS_MODE_DIFF];
  assign old_val = drain_data.bank ? tab_b[drain_data.idx] : tab_a[drain_data.idx];
  assign new_val = mode_reg[`DTS_MODE_MAXHOLD] ? max8(old_val, drain_data.data)
                                               : drain_data.data;

  always_ff @(posedge clk_sys_in)
  begin
    if (drain_take && drain_data.bank)
      tab_b[drain_data.idx] <= new_val;
    if (drain_take && !drain_data.bank && !a_hold)
      tab_a[drain_data.idx] <= new_val;
  end

  // Display walk over 1000 points, one per tick
  logic [8:0] d_idx;
  logic [7:0] ya;
  logic [7:0] yb;
  logic [7:0] y_sel;
  logic       both;
  assign d_idx = dptr_reg[9:1];
  assign ya    = tab_a[d_idx];
  assign yb    = tab_b[d_idx];
  assign both  = mode_reg[`DTS_MODE_VIEW_A] && mode_reg[`DTS_MODE_VIEW_B];

  // Y source selection by mode
  always_comb
  begin
    if (mode_reg[`DTS_MODE_DIFF])
      y_sel = sat_sub(yb, ya);
    else if (both && !mode_reg[`DTS_MODE_FREEZE])
      y_sel = dptr_reg[0] ? yb : ya;
    else if (both)
      y_sel = trace_reg ? yb : ya;  // Separate traces
    else if (mode_reg[`DTS_MODE_VIEW_B])
      y_sel = yb;
    else
      y_sel = ya;
  end

  // Display outputs and markers
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dptr_reg        <= 10'h000;
      trace_reg       <= 1'b0;
      disp_x_out      <= 10'h000;
      disp_y_out      <= 8'h00;
      disp_trace_out  <= 1'b0;
      upd_marker_out  <= 1'b0;
      wave_marker_out <= 1'b0;
    end
    else if (tick_reg)
    begin
      disp_x_out      <= dptr_reg;
      disp_y_out      <= y_sel;
      disp_trace_out  <= trace_reg;
      upd_marker_out  <= (acq_reg != DTS_ACQ_IDLE) && (d_idx == acq_x_reg[9:1]);
      wave_marker_out <= (dptr_reg == mark1_reg) || (dptr_reg == mark2_reg);
      if (dptr_reg == 10'(`DTS_DISP_POINTS - 1))
      begin
        dptr_reg  <= 10'h000;
        trace_reg <= ~trace_reg;
      end
      else
        dptr_reg <= dptr_reg + 10'h001;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  property p_tick_gap;
    tick_reg |=> !tick_reg [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too close");

  property p_drain_tick;
    drain_valid && !tick_reg |=> drain_valid;
  endproperty
  a_drain_tick: assert property (p_drain_tick) else $error("drain off tick");

  property p_idx_range;
    drain_valid |-> drain_data.idx < 9'(`DTS_POINTS);
  endproperty
  a_idx_range: assert property (p_idx_range) else $error("index out of table");

  property p_freeze_a;
    drain_take && !drain_data.bank && a_hold |=> tab_a[$past(drain_data.idx)] == $past(old_val);
  endproperty
  a_freeze_a: assert property (p_freeze_a) else $error("frozen A written");

  property p_b_update;
    drain_take && drain_data.bank |=> tab_b[$past(drain_data.idx)] == $past(new_val);
  endproperty
  a_b_update: assert property (p_b_update) else $error("B not updated");

  property p_diff_clip;
    tick_reg && mode_reg[`DTS_MODE_DIFF] && ya > yb |=> disp_y_out == 8'h00;
  endproperty
  a_diff_clip: assert property (p_diff_clip) else $error("difference wrapped");

  property p_sub_write;
    wr_ctrl |=> sub_reg == $past(wdat_s[2:0]);
  endproperty
  a_sub_write: assert property (p_sub_write) else $error("subaddress not taken");

  property p_rd_inc;
    rd_store && rdptr_reg < 9'(`DTS_POINTS - 1) |=> rdptr_reg == $past(rdptr_reg) + 9'h001;
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("read pointer stuck");

  property p_maxhold;
    drain_take && drain_data.bank && mode_reg[`DTS_MODE_MAXHOLD]
      |=> tab_b[$past(drain_data.idx)] >= $past(old_val);
  endproperty
  a_maxhold: assert property (p_maxhold) else $error("max hold lowered");
endmodule

/* bench/dts_cpu_model.sv */
// Behavioural control processor that drives the instrument bus
`timescale 1ns/1ps
module dts_cpu_model
(
  // Clock
  input  wire logic       clk_in,
  // Bus towards the storage block
  output logic [7:0]      addr_out,
  output logic [7:0]      data_out,
  output logic            wr_out,
  output logic            rd_out,
  input  wire logic [7:0] data_in,
  input  wire logic       data_oe_in
);
  // Strobe length in edges; raise it to act as a slow controller
  int hold_cyc = 6;

  // Idle bus at time zero
  initial
  begin
    addr_out = 8'h00;
    data_out = 8'h00;
    wr_out   = 1'b0;
    rd_out   = 1'b0;
  end

  // Write cycle, address and data held for the whole strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    wr_out   <= 1'b1;
    repeat (hold_cyc) @(posedge clk_in);
    // Released lines show the inverse so stale data never looks valid
    wr_out   <= 1'b0;
    addr_out <= ~a;
    data_out <= ~d;
    // Low gap well above the two-edge minimum
    repeat (4) @(posedge clk_in);
  endtask

  // Read cycle; data and enable taken at the releasing edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    repeat (hold_cyc) @(posedge clk_in);
    d        = data_in;
    oe       = data_oe_in;
    rd_out   <= 1'b0;
    addr_out <= ~a;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

/* bench/tb_top.sv */
// Self-checking testbench for the dual trace storage block
`timescale 1ns/1ps
`include "dts_defines.svh"
module tb_top;
  // Clock, reset and sample pins
  logic       clk_sys_in = 1'b0;
  logic       resetn_in  = 1'b0;
  logic [7:0] y_code     = 8'h00;
  logic [9:0] x_code     = 10'h000;
  logic       smp_strobe = 1'b0;
  // Bus and display wires
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic       bus_oe;
  logic [9:0] disp_x;
  logic [7:0] disp_y;
  logic       disp_trace;
  logic       upd_marker;
  logic       wave_marker;
  // Scoreboard counters
  int         n_mismatch = 0;
  int         n_compared = 0;

  // 200 MHz system clock
  always #2.5 clk_sys_in = ~clk_sys_in;

  // Controller model on the bus
  dts_cpu_model cpu_u (.clk_in(clk_sys_in), .addr_out(bus_addr), .data_out(bus_wdata),
    .wr_out(bus_wr), .rd_out(bus_rd), .data_in(bus_rdata), .data_oe_in(bus_oe));

  // Block under test
  dts_top dut_u (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .y_code_in(y_code),
    .x_code_in(x_code), .sample_strobe_in(smp_strobe), .bus_addr_in(bus_addr),
    .bus_data_in(bus_wdata), .bus_wr_in(bus_wr), .bus_rd_in(bus_rd),
    .bus_data_out(bus_rdata), .bus_data_oe_out(bus_oe), .disp_x_out(disp_x),
    .disp_y_out(disp_y), .disp_trace_out(disp_trace), .upd_marker_out(upd_marker),
    .wave_marker_out(wave_marker));

  // Byte comparison
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Flag comparison
  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One sample; long wait so each commit meets a free tick
  task automatic smp(input logic [9:0] x, input logic [7:0] y);
    @(posedge clk_sys_in);
    x_code <= x;
    y_code <= y;
    repeat (2) @(posedge clk_sys_in);
    smp_strobe <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    smp_strobe <= 1'b0;
    repeat (250) @(posedge clk_sys_in);
  endtask

  // Subaddress chosen first, then the store port written
  task automatic set_reg(input logic [2:0] sub, input logic [7:0] v);
    cpu_u.wr(`DTS_ADDR_CTRL_WR, {5'h00, sub});
    cpu_u.wr(`DTS_ADDR_STORE_WR, v);
  endtask

  // Table entry read through the pointer; returns the byte and enable
  task automatic rd_tab(input logic b, input logic [8:0] i, output logic [7:0] d,
                        output logic oe);
    set_reg(3'h5, i[7:0]);
    set_reg(3'h6, {6'h00, b, i[8]});
    cpu_u.rd(`DTS_ADDR_STORE_RD, d, oe);
  endtask

  // Store points in both tables, including the last index
  task automatic test_store;
    logic [7:0] d;
    logic       oe;
    set_reg(3'h1, 8'h00);
    smp(10'd998, 8'h3c);
    smp(10'd0, 8'h11);
    smp(10'd10, 8'h55);
    smp(10'd11, 8'ha6);
    smp(10'd20, 8'h00);
    smp(10'd21, 8'h00);
    rd_tab(1'b0, 9'd5, d, oe);
    chk1("read enable", 1'b1, oe);
    chk8("table A 5", 8'h55, d);
    rd_tab(1'b1, 9'd5, d, oe);
    chk8("table B 5", 8'ha6, d);
    rd_tab(1'b0, 9'd499, d, oe);
    chk8("table A 499", 8'h3c, d);
    cpu_u.rd(`DTS_ADDR_STORE_RD, d, oe);
    chk8("table A wrap", 8'h11, d);
    $display("test store done");
  endtask

  // Freeze keeps A while B follows the sweep
  task automatic test_freeze;
    logic [7:0] d;
    logic       oe;
    set_reg(3'h0, 8'h1a);
    smp(10'd10, 8'h99);
    smp(10'd11, 8'h77);
    smp(10'd20, 8'h00);
    rd_tab(1'b0, 9'd5, d, oe);
    chk8("frozen A 5", 8'h55, d);
    rd_tab(1'b1, 9'd5, d, oe);
    chk8("live B 5", 8'h77, d);
    cpu_u.rd(`DTS_ADDR_STATUS_RD, d, oe);
    chk8("status flags", 8'h08, d & 8'hcc);
    $display("test freeze done");
  endtask

  // Max hold keeps the larger of stored and new value
  task automatic test_maxhold;
    logic [7:0] d;
    logic       oe;
    set_reg(3'h0, 8'h19);
    smp(10'd11, 8'h20);
    smp(10'd20, 8'h00);
    rd_tab(1'b1, 9'd5, d, oe);
    chk8("held B 5", 8'h77, d);
    smp(10'd11, 8'hf0);
    smp(10'd20, 8'h00);
    rd_tab(1'b1, 9'd5, d, oe);
    chk8("raised B 5", 8'hf0, d);
    $display("test maxhold done");
  endtask

  // Below threshold the halving mean is kept, above it the peak
  task automatic test_average;
    logic [7:0] d;
    logic       oe;
    set_reg(3'h0, 8'h18);
    set_reg(3'h1, 8'hff);
    smp(10'd12, 8'h40);
    smp(10'd12, 8'h60);
    smp(10'd20, 8'h00);
    rd_tab(1'b0, 9'd6, d, oe);
    chk8("average A 6", 8'h50, d);
    set_reg(3'h1, 8'h50);
    smp(10'd14, 8'h20);
    smp(10'd14, 8'h70);
    smp(10'd20, 8'h00);
    rd_tab(1'b0, 9'd7, d, oe);
    chk8("peak A 7", 8'h70, d);
    $display("test average done");
  endtask

  // Vertical section answers status with the live level; unmapped address refused
  task automatic test_section;
    logic [7:0] d;
    logic       oe;
    y_code <= 8'h5a;
    cpu_u.wr(`DTS_ADDR_CTRL_WR, 8'h08);
    cpu_u.rd(`DTS_ADDR_STATUS_RD, d, oe);
    chk8("vertical status", 8'h5a, d);
    cpu_u.wr(`DTS_ADDR_CTRL_WR, 8'h00);
    cpu_u.rd(8'hfc, d, oe);
    chk1("unmapped enable", 1'b0, oe);
    $display("test section done");
  endtask

  // Bounded wait until the display shows a given point
  task automatic wait_x(input logic [9:0] x);
    int k;
    k = 0;
    while (disp_x !== x && k < 30000)
    begin
      @(posedge clk_sys_in);
      k++;
    end
    chk1("display point reached", 1'b1, disp_x === x);
  endtask

  // Display walk: interlaced views, markers and clipped difference
  task automatic test_display;
    smp(10'd80, 8'h30);
    smp(10'd81, 8'h70);
    smp(10'd82, 8'h50);
    smp(10'd83, 8'h20);
    smp(10'd84, 8'h10);
    smp(10'd85, 8'h35);
    smp(10'd90, 8'h00);
    set_reg(3'h2, 8'h51);
    wait_x(10'd80);
    chk8("interlaced A 40", 8'h30, disp_y);
    chk1("trace first pass", 1'b0, disp_trace);
    chk1("marker off 80", 1'b0, wave_marker);
    chk1("update off 80", 1'b0, upd_marker);
    wait_x(10'd81);
    chk8("interlaced B 40", 8'h70, disp_y);
    chk1("marker on 81", 1'b1, wave_marker);
    set_reg(3'h0, 8'h1c);
    wait_x(10'd82);
    chk8("clipped diff 41", 8'h00, disp_y);
    wait_x(10'd84);
    chk8("diff 42", 8'h25, disp_y);
    wait_x(10'd90);
    chk1("update on 90", 1'b1, upd_marker);
    $display("test display done");
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    chk1("enable in reset", 1'b0, bus_oe);
    repeat (6) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    test_store;
    test_freeze;
    test_maxhold;
    test_average;
    test_section;
    test_display;
    complete_run;
  end

  // Watchdog well beyond the expected span
  initial
  begin
    repeat (40000) @(posedge clk_sys_in);
    n_mismatch++;
    $display("watchdog expired");
    complete_run;
  end
endmodule
